// ---- hdl/rtc_osc_alarm_watchdog.sv ----
// rtc timekeeping support: oscillator control, calibration, alarm,
// watchdog and power monitor trigger behind an async memory bus
// assumes bus, supply and oscillator pins are asynchronous to core_clk
//
// Overview of operation
// - stop bit at 1 halts the oscillator, 0 lets it run
// - stop bit is retained storage and comes up at 0, running
// - after stop is cleared the oscillator needs about five seconds to start
// - on supply rise, wanted but dead oscillator sets the fail flag
// - on oscillator failure time reloads from base; control bits untouched
// - five-bit calibration magnitude, bit 5 sign: 1 positive, 0 negative
// - 64 minute cycle; first 62 minutes may trim one second
// - magnitude n trims only the first 2n minutes of each cycle
// - test bit toggles the interrupt output at 512 Hz, uncalibrated
// - alarm compares date, hours, minutes, seconds; match bit 0 includes
// - all match bits 1 fires every second; more fields fire rarer
// - alarm match sets the alarm flag and may drive interrupt
// - reading the flags register clears all its flags
// - watchdog counts down at 32 Hz only while the oscillator runs
// - watchdog loads on power up and reloads on restart bit write
// - reaching zero sets the expired flag and optionally interrupts
// - timeout writes take effect only while the write lock is 0
// - a timeout value of zero disables the watchdog
// - expired flag stays set until the flags register is read
// - supply falling to threshold starts a store and selects backup
// - read clears flags only after a complete read cycle with write high; writing fail bit 0 also clears the fail flag
// - watchdog interrupt enable routes timeouts to the interrupt output
`timescale 1ns/1ns
module rtc_osc_alarm_watchdog
#(
    parameter int START_CYCLES = rtc_pkg::START_CYC_DEF
)
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // memory bus pins
    input  wire logic                       ce_b,
    input  wire logic                       we_b,
    input  wire logic                       oe_b,
    input  wire logic [rtc_pkg::ADDR_W-1:0] addr,
    input  wire logic [rtc_pkg::DATA_W-1:0] dq_in,
    output logic      [rtc_pkg::DATA_W-1:0] dq_out,
    output logic                            dq_oe_b,
    // supply and oscillator status
    input  wire logic                       vcc_ok,
    input  wire logic                       osc_halted,
    // outputs
    output logic                            int_out,
    output logic                            store_start,
    output logic                            backup_sel
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [1:0]      ce_s;
        logic [1:0]      we_s;
        logic [1:0]      oe_s;
        logic [1:0]      vcc_s;
        logic [1:0]      halt_s;
        logic [16:0]     a1;
        logic [16:0]     a2;
        logic [7:0]      d1;
        logic [7:0]      d2;
        logic            ce_p;
        logic            wr_p;
        logic            rd_ok;
        logic            vcc_p;
        logic [16:0]     la;
        logic [7:0]      ld;
        logic            watchdog_expired_flag;
        logic            af;
        logic            pf;
        logic            oscillator_fail_flag;
        logic            cal_t;
        logic            wbit;
        logic            rbit;
        logic            osc_stop;
        logic            cal_sign;
        logic [4:0]      cal_mag;
        logic            timeout_write_lock;
        logic [5:0]      wdt;
        logic [5:0]      wd_cnt;
        logic            watchdog_irq_enable;
        logic            aie;
        logic            pfe;
        logic [3:0][7:0] alm;
        logic [3:0][7:0] base;
        logic [3:0][7:0] tm;
        logic [28:0]     start_cnt;
        logic            osc_run;
        logic            tick_d;
        logic [7:0]      dq_out;
        logic            dq_oe_b;
        logic            int_q;
        logic            store_q;
        logic            backup_q;
    } st_t;

    localparam st_t ST_RST = '{ce_s: 2'b11, we_s: 2'b11, oe_s: 2'b11,
                               ce_p: 1'b1, dq_oe_b: 1'b1,
                               osc_stop: OSC_STOP_RST, wdt: WDT_RST,
                               osc_run: ~OSC_STOP_RST, default: '0};

    st_t             q;
    st_t             d;
    logic [1:0]      rsync;
    logic            rst_i_b;
    logic            ce;
    logic            we;
    logic            oe;
    logic            vcc;
    logic            alive;
    logic            wr_act;
    logic            wr_end;
    logic            flags_rd;
    logic            wds_wr;
    logic            pwr_up;
    logic            pwr_dn;
    logic            match;
    logic            car;
    logic [8:0]      c;
    logic [3:0][7:0] nt;
    logic            sec_pulse;
    logic            wd_tick;
    logic            test_wave;

    // bcd increment with wrap; bit 8 is the carry out
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] top,
                                           input logic [7:0] lo);
        logic [8:0] r;
        r = {1'b0, v + 8'h01};
        if (v == top)
            r = {1'b1, lo};
        else if (v[3:0] == 4'h9)
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        return r;
    endfunction

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rsync <= 2'b00;
        else
            rsync <= {rsync[0], 1'b1};
    end
    assign rst_i_b = rsync[1];

    rtc_tick_divider u_div
    (
        .core_clk  (core_clk),
        .rst_i_b   (rst_i_b),
        .run       (alive),
        .cal_sign  (q.cal_sign),
        .cal_mag   (q.cal_mag),
        .sec_pulse (sec_pulse),
        .wd_tick   (wd_tick),
        .test_wave (test_wave)
    );

    // synchronised views of the pins
    assign ce     = q.ce_s[1];
    assign we     = q.we_s[1];
    assign oe     = q.oe_s[1];
    assign vcc    = q.vcc_s[1];
    assign alive  = q.osc_run && !q.halt_s[1];
    assign wr_act = !ce && !we;
    assign wr_end = q.wr_p && !wr_act;
    assign flags_rd = !q.ce_p && ce && q.rd_ok && q.la == FLAGS_OFS;
    assign wds_wr = wr_end && q.la == WD_OFS && q.ld[WD_RST];
    assign pwr_up = vcc && !q.vcc_p;
    assign pwr_dn = !vcc && q.vcc_p;

    // next time of day and alarm compare
    always_comb
    begin
        nt = q.tm;
        car = 1'b1;
        c = 9'h000;
        match = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (car)
            begin
                c = bcd_inc(q.tm[i], TM_TOP[i], TM_LO[i]);
                nt[i] = c[7:0];
                car = c[8];
            end
            if (!q.alm[i][ALM_M] && q.alm[i][6:0] != q.tm[i][6:0])
                match = 1'b0;
        end
    end

    always_comb
    begin
        d = q;
        // pin synchronisers
        d.ce_s   = {q.ce_s[0], ce_b};
        d.we_s   = {q.we_s[0], we_b};
        d.oe_s   = {q.oe_s[0], oe_b};
        d.vcc_s  = {q.vcc_s[0], vcc_ok};
        d.halt_s = {q.halt_s[0], osc_halted};
        d.a1 = addr;
        d.a2 = q.a1;
        d.d1 = dq_in;
        d.d2 = q.d1;
        d.ce_p = ce;
        d.wr_p = wr_act;
        d.vcc_p = vcc;
        d.store_q = 1'b0;
        d.tick_d = 1'b0;

        // a cycle counts as a read only if write stayed high throughout
        if (ce)
            d.rd_ok = 1'b0;
        else
            d.rd_ok = (q.ce_p || q.rd_ok) && we;
        if (!ce)
            d.la = q.a2;
        if (wr_act)
            d.ld = q.d2;

        // oscillator start delay after the stop bit is cleared
        if (q.start_cnt != 29'h0)
        begin
            d.start_cnt = q.start_cnt - 29'h1;
            if (q.start_cnt == 29'h1)
                d.osc_run = 1'b1;
        end

        // clears first, so any set below in the same cycle wins
        if (flags_rd)
        begin
            d.watchdog_expired_flag = 1'b0;
            d.af = 1'b0;
            d.pf = 1'b0;
            d.oscillator_fail_flag = 1'b0;
        end

        // register writes at the end of the write strobe
        if (wr_end)
        begin
            case (q.la)
                FLAGS_OFS:
                begin
                    if (!q.ld[FL_OSCILLATOR_FAIL_FLAG])
                        d.oscillator_fail_flag = 1'b0;
                    d.cal_t = q.ld[FL_CAL];
                    d.wbit = q.ld[FL_W];
                    d.rbit = q.ld[FL_R];
                    if (q.wbit && !q.ld[FL_W])
                        d.tm = q.base;
                end
                WD_OFS:
                begin
                    d.timeout_write_lock = q.ld[WD_LOCK];
                    if (!q.timeout_write_lock)
                        d.wdt = q.ld[5:0];
                    if (q.ld[WD_RST])
                        d.wd_cnt = q.timeout_write_lock ? q.wdt : q.ld[5:0];
                end
                CAL_OFS:
                begin
                    d.osc_stop = q.ld[CAL_STOP];
                    d.cal_sign = q.ld[CAL_SIGN];
                    d.cal_mag = q.ld[4:0];
                    if (q.ld[CAL_STOP])
                    begin
                        d.osc_run = 1'b0;
                        d.start_cnt = 29'h0;
                    end
                    else if (q.osc_stop)
                        d.start_cnt = 29'(START_CYCLES);
                end
                IRQ_OFS:
                begin
                    d.watchdog_irq_enable = q.ld[IRQ_WIE];
                    d.aie = q.ld[IRQ_AIE];
                    d.pfe = q.ld[IRQ_PFE];
                end
                ALM_SEC_OFS:  d.alm[0] = q.ld;
                ALM_MIN_OFS:  d.alm[1] = q.ld;
                ALM_HR_OFS:   d.alm[2] = q.ld;
                ALM_DATE_OFS: d.alm[3] = q.ld;
                SEC_OFS:      d.base[0] = q.ld;
                MIN_OFS:      d.base[1] = q.ld;
                HR_OFS:       d.base[2] = q.ld;
                DATE_OFS:     d.base[3] = q.ld;
                default:;
            endcase
        end

        // time counters advance once a second unless being set
        if (sec_pulse && alive && !q.wbit)
        begin
            d.tm = nt;
            d.tick_d = 1'b1;
        end
        if (q.tick_d && match)
            d.af = 1'b1;

        // watchdog; a restart write in the same cycle keeps its reload
        if (wd_tick && alive && q.wdt != 6'h00 && !wds_wr)
        begin
            if (q.wd_cnt <= 6'h01)
            begin
                d.watchdog_expired_flag = 1'b1;
                d.wd_cnt = q.wdt;
            end
            else
                d.wd_cnt = q.wd_cnt - 6'h01;
        end

        // power monitor
        if (pwr_up)
        begin
            d.wd_cnt = q.wdt;
            d.backup_q = 1'b0;
            if (!q.osc_stop && !alive)
            begin
                d.oscillator_fail_flag = 1'b1;
                d.tm = q.base;
            end
        end
        if (pwr_dn)
        begin
            d.pf = 1'b1;
            d.store_q = 1'b1;
            d.backup_q = 1'b1;
        end

        // read data and pin drive
        d.dq_oe_b = !(!ce && we && !oe && q.a2[16:4] == RTC_PAGE);
        case (q.a2)
            FLAGS_OFS:    d.dq_out = {q.watchdog_expired_flag, q.af, q.pf, q.oscillator_fail_flag, 1'b0,
                                      q.cal_t, q.wbit, q.rbit};
            WD_OFS:       d.dq_out = {1'b0, q.timeout_write_lock, q.wdt};
            CAL_OFS:      d.dq_out = {q.osc_stop, 1'b0, q.cal_sign,
                                      q.cal_mag};
            IRQ_OFS:      d.dq_out = {q.watchdog_irq_enable, q.aie, q.pfe, 5'h00};
            ALM_SEC_OFS:  d.dq_out = q.alm[0];
            ALM_MIN_OFS:  d.dq_out = q.alm[1];
            ALM_HR_OFS:   d.dq_out = q.alm[2];
            ALM_DATE_OFS: d.dq_out = q.alm[3];
            SEC_OFS:      d.dq_out = q.tm[0];
            MIN_OFS:      d.dq_out = q.tm[1];
            HR_OFS:       d.dq_out = q.tm[2];
            DATE_OFS:     d.dq_out = q.tm[3];
            default:      d.dq_out = 8'h00;
        endcase

        // interrupt level, or the raw test wave in test mode
        d.int_q = q.cal_t ? test_wave
                : (q.watchdog_expired_flag && q.watchdog_irq_enable) || (q.af && q.aie)
                  || (q.pf && q.pfe);
    end

    always_ff @(posedge core_clk or negedge rst_i_b)
    begin
        if (!rst_i_b)
            q <= ST_RST;
        else
            q <= d;
    end

    assign dq_out      = q.dq_out;
    assign dq_oe_b     = q.dq_oe_b;
    assign int_out     = q.int_q;
    assign store_start = q.store_q;
    assign backup_sel  = q.backup_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_i_b);

    property p_stop_halts;
        q.osc_stop |-> !q.osc_run;
    endproperty
    a_stop_halts: assert property (p_stop_halts)
        else $error("oscillator runs while stopped");

    property p_start_delay;
        $fell(q.osc_stop) |-> !q.osc_run [*8];
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("oscillator started without delay");

    property p_fail_flag;
        pwr_up && !q.osc_stop && !alive |=> q.oscillator_fail_flag;
    endproperty
    a_fail_flag: assert property (p_fail_flag)
        else $error("fail flag not set on dead oscillator");

    property p_base_reload;
        pwr_up && !q.osc_stop && !alive |=> q.tm == $past(q.base);
    endproperty
    a_base_reload: assert property (p_base_reload)
        else $error("time not reloaded from base");

    property p_lock;
        wr_end && q.la == WD_OFS && q.timeout_write_lock |=> $stable(q.wdt);
    endproperty
    a_lock: assert property (p_lock)
        else $error("timeout changed while locked");

    property p_wd_off;
        q.wdt == 6'h00 && !q.watchdog_expired_flag |=> !q.watchdog_expired_flag;
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("watchdog expired with zero timeout");

    property p_read_clear;
        flags_rd && !q.tick_d && !wd_tick |=> !q.af && !q.watchdog_expired_flag;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("flags not cleared by read");

    property p_alarm;
        q.tick_d && match |=> q.af;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm match lost");

    property p_wd_int;
        q.watchdog_expired_flag && q.watchdog_irq_enable && !q.cal_t |=> q.int_q;
    endproperty
    a_wd_int: assert property (p_wd_int)
        else $error("watchdog interrupt not driven");

    property p_switch;
        pwr_dn |=> q.store_q && q.backup_q ##1 !q.store_q;
    endproperty
    a_switch: assert property (p_switch)
        else $error("store or backup switch missing");

    property p_wd_freeze;
        !alive && !wds_wr && !pwr_up |=> $stable(q.wd_cnt);
    endproperty
    a_wd_freeze: assert property (p_wd_freeze)
        else $error("watchdog counted with oscillator stopped");
endmodule

// ---- hdl/rtc_pkg.sv ----
// constants shared by the rtc timekeeping support block
// assumes a 100 MHz core clock and a 32.768 kHz nominal time base
package rtc_pkg;
    // clocks and bus geometry
    localparam int CORE_HZ = 100_000_000;
    localparam int OSC_HZ  = 32_768;
    localparam int ADDR_W  = 17;
    localparam int DATA_W  = 8;

    // register offsets
    localparam logic [16:0] FLAGS_OFS    = 17'h1fff0;
    localparam logic [16:0] ALM_SEC_OFS  = 17'h1fff2;
    localparam logic [16:0] ALM_MIN_OFS  = 17'h1fff3;
    localparam logic [16:0] ALM_HR_OFS   = 17'h1fff4;
    localparam logic [16:0] ALM_DATE_OFS = 17'h1fff5;
    localparam logic [16:0] IRQ_OFS      = 17'h1fff6;
    localparam logic [16:0] WD_OFS       = 17'h1fff7;
    localparam logic [16:0] CAL_OFS      = 17'h1fff8;
    localparam logic [16:0] SEC_OFS      = 17'h1fff9;
    localparam logic [16:0] MIN_OFS      = 17'h1fffa;
    localparam logic [16:0] HR_OFS       = 17'h1fffb;
    localparam logic [16:0] DATE_OFS     = 17'h1fffd;
    localparam logic [12:0] RTC_PAGE     = 13'h1fff;

    // field positions
    localparam int FL_WDF  = 7;
    localparam int FL_AF   = 6;
    localparam int FL_PF   = 5;
    localparam int FL_OSCILLATOR_FAIL_FLAG = 4;
    localparam int FL_CAL  = 2;
    localparam int FL_W    = 1;
    localparam int FL_R    = 0;
    localparam int WD_RST  = 7;
    localparam int WD_LOCK = 6;
    localparam int CAL_STOP = 7;
    localparam int CAL_SIGN = 5;
    localparam int IRQ_WIE = 7;
    localparam int IRQ_AIE = 6;
    localparam int IRQ_PFE = 5;
    localparam int ALM_M   = 7;

    // reset values
    localparam logic       OSC_STOP_RST = 1'b0;
    localparam logic [5:0] WDT_RST      = 6'h00;

    // timing
    localparam int OSC_START_MS  = 5000;
    localparam int START_CYC_DEF = OSC_START_MS * (CORE_HZ / 1000);
    localparam int WD_PERIOD_US  = 31250;
    localparam int WD_DIV = WD_PERIOD_US * OSC_HZ / 1_000_000;
    localparam int TEST_HZ   = 512;
    localparam int TEST_HALF = OSC_HZ / (2 * TEST_HZ);
    localparam int CAL_SHORT = 128;
    localparam int CAL_LONG  = 256;
    localparam int CAL_ACT_MIN = 62;
    localparam int SEC_PER_MIN = 60;

    // bcd time field limits, index 0 seconds .. 3 date
    localparam logic [3:0][7:0] TM_TOP = {8'h31, 8'h23, 8'h59, 8'h59};
    localparam logic [3:0][7:0] TM_LO  = {8'h01, 8'h00, 8'h00, 8'h00};
endpackage

// ---- hdl/rtc_tick_divider.sv ----
// oscillator divider: calibrated one-second pulse, 32 Hz tick, test wave
// assumes run is a same-clock level from the parent block
`timescale 1ns/1ns
module rtc_tick_divider
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_i_b,
    // control
    input  wire logic       run,
    input  wire logic       cal_sign,
    input  wire logic [4:0] cal_mag,
    // ticks
    output logic            sec_pulse,
    output logic            wd_tick,
    output logic            test_wave
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [27:0] acc;
        logic [14:0] raw;
        logic [16:0] scnt;
        logic [5:0]  sec_m;
        logic [5:0]  min_c;
        logic        sec_p;
        logic        wd_p;
        logic        wave;
    } div_t;

    localparam logic [14:0] WD_MASK   = 15'(WD_DIV - 1);
    localparam logic [14:0] HALF_MASK = 15'(TEST_HALF - 1);

    div_t        q;
    div_t        d;
    logic [27:0] sum;
    logic [16:0] slen;
    logic        osc;

    // fractional step turns the core clock into oscillator edges
    always_comb
    begin
        d = q;
        d.sec_p = 1'b0;
        d.wd_p = 1'b0;
        osc = 1'b0;
        sum = q.acc + 28'(OSC_HZ);
        slen = 17'(OSC_HZ);
        if (run)
        begin
            osc = sum >= 28'(CORE_HZ);
            d.acc = osc ? sum - 28'(CORE_HZ) : sum;
        end
        // one second of the first 2n minutes is trimmed
        if (q.sec_m == 6'h00 && q.min_c < 6'(CAL_ACT_MIN)
            && q.min_c < {cal_mag, 1'b0})
        begin
            slen = cal_sign ? 17'(OSC_HZ - CAL_SHORT)
                            : 17'(OSC_HZ + CAL_LONG);
        end
        if (osc)
        begin
            // raw count is never trimmed, so the test wave is unaffected
            d.raw = q.raw + 15'h0001;
            d.wd_p = (q.raw & WD_MASK) == WD_MASK;
            if ((q.raw & HALF_MASK) == HALF_MASK)
                d.wave = ~q.wave;
            if (q.scnt >= slen - 17'h00001)
            begin
                d.scnt = 17'h00000;
                d.sec_p = 1'b1;
                d.sec_m = (q.sec_m == 6'(SEC_PER_MIN - 1)) ? 6'h00
                                                          : q.sec_m + 6'h01;
                if (q.sec_m == 6'(SEC_PER_MIN - 1))
                    d.min_c = q.min_c + 6'h01;
            end
            else
                d.scnt = q.scnt + 17'h00001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_i_b)
    begin
        if (!rst_i_b)
            q <= '0;
        else
            q <= d;
    end

    assign sec_pulse = q.sec_p;
    assign wd_tick   = q.wd_p;
    assign test_wave = q.wave;

    // a trimmed second never exceeds its lengthened bound
    property p_sec_len;
        @(posedge core_clk) disable iff (!rst_i_b)
        q.scnt <= 17'(OSC_HZ + CAL_LONG);
    endproperty
    a_sec_len: assert property (p_sec_len)
        else $error("second counter beyond longest second");
endmodule

// ---- sim/host_bus_model.sv ----
// host side of the async memory bus: sram style cycles on request
// assumes the device syncs its pins through two flops
`timescale 1ns/1ns
module host_bus_model
(
    // clock
    input  wire logic        core_clk,
    // bus pins toward the device
    output logic             ce_b,
    output logic             we_b,
    output logic             oe_b,
    output logic [16:0]      addr,
    output logic [7:0]       dq_in,
    // read return
    input  wire logic [7:0]  dq_out,
    input  wire logic        dq_oe_b
);
    // idle bus at time zero
    initial
    begin
        ce_b  = 1'b1;
        we_b  = 1'b1;
        oe_b  = 1'b1;
        addr  = 17'h00000;
        dq_in = 8'h00;
    end

    // hold every pin 6 clocks, longer than the 3 edge sync and answer
    task automatic cyc(input logic [16:0] a, input logic [7:0] d,
                       input logic wr, output logic [7:0] q,
                       output logic drv_b);
        @(posedge core_clk);
        ce_b  <= 1'b0;
        we_b  <= ~wr;
        oe_b  <= wr;
        addr  <= a;
        dq_in <= d;
        repeat (6) @(posedge core_clk);
        q = dq_out;
        drv_b = dq_oe_b;
        ce_b  <= 1'b1;
        we_b  <= 1'b1;
        oe_b  <= 1'b1;
        // released lines scrambled so stale values never match
        addr  <= ~a;
        dq_in <= ~d;
        repeat (6) @(posedge core_clk);
    endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking run for the rtc support block
// assumes host_bus_model speaks the bus; supply pins driven here
`timescale 1ns/1ns
module testbench;
    import rtc_pkg::*;
    logic        core_clk, rst_b, vcc_ok, osc_halted, drv_b;
    logic        ce_b, we_b, oe_b, dq_oe_b, int_out, store_start, backup_sel;
    logic [16:0] addr;
    logic [7:0]  dq_in, dq_out, q;
    int          mismatches, n_tests, cycles, pulses;

    // short start delay keeps the run brief
    rtc_osc_alarm_watchdog #(.START_CYCLES(20)) DUT
    (
        .core_clk(core_clk), .rst_b(rst_b), .ce_b(ce_b), .we_b(we_b),
        .oe_b(oe_b), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_b(dq_oe_b), .vcc_ok(vcc_ok), .osc_halted(osc_halted),
        .int_out(int_out), .store_start(store_start),
        .backup_sel(backup_sel)
    );
    host_bus_model host
    (
        .core_clk(core_clk), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b)
    );

    // clock, hang guard and store pulse count
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (store_start === 1'b1)
            pulses <= pulses + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [16:0] a);
        host.cyc(a, 8'h00, 1'b0, q, drv_b);
    endtask
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        host.cyc(a, d, 1'b1, q, drv_b);
    endtask

    // reset values, read clear, decode and reserved bit
    task automatic t_regs;
        rd(FLAGS_OFS);
        chk("fail flag", 8'h10, q);
        rd(FLAGS_OFS);
        chk("flags read clear", 8'h00, q);
        rd(CAL_OFS);
        chk("cal reset", 8'h00, q);
        chk("cal drive", 8'h00, {7'h0, drv_b});
        rd(WD_OFS);
        chk("timeout reset", 8'h00, q);
        rd(17'h1fff1);
        chk("unmapped", 8'h00, q);
        wr(ALM_SEC_OFS, 8'h85);
        rd(ALM_SEC_OFS);
        chk("alarm seconds", 8'h85, q);
        rd(17'h00100);
        chk("ram drive", 8'h01, {7'h0, drv_b});
        wr(CAL_OFS, 8'hff);
        rd(CAL_OFS);
        chk("cal", 8'hbf, q);
    endtask

    // lock from the previous write guards the timeout field
    task automatic t_wdog;
        wr(WD_OFS, 8'h03);
        rd(WD_OFS);
        chk("timeout", 8'h03, q);
        wr(WD_OFS, 8'h4a);
        rd(WD_OFS);
        chk("lock set", 8'h4a, q);
        wr(WD_OFS, 8'hc5);
        rd(WD_OFS);
        chk("locked", 8'h4a, q);
    endtask

    // supply drop and return with the oscillator dead
    task automatic t_power(input logic [7:0] cal, input logic clr,
                           input logic [7:0] fl);
        wr(CAL_OFS, cal);
        wr(IRQ_OFS, 8'h20);
        // with W left at 0, base time reaches the live seconds only through a fail reload
        wr(SEC_OFS, 8'h42);
        pulses = 0;
        @(posedge core_clk);
        vcc_ok <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk("backup on", 8'h01, {7'h0, backup_sel});
        chk("store pulses", 8'h01, pulses[7:0]);
        chk("pf irq", 8'h01, {7'h0, int_out});
        vcc_ok <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("backup off", 8'h00, {7'h0, backup_sel});
        // clearing pass also enters test mode: pin shows the idle wave
        if (clr)
            wr(FLAGS_OFS, 8'h04);
        chk("irq or test wave", {7'h0, ~clr}, {7'h0, int_out});
        rd(FLAGS_OFS);
        chk("flags", fl, q);
        rd(FLAGS_OFS);
        chk("flags cleared", fl & 8'h0f, q);
        chk("irq cleared", 8'h00, {7'h0, int_out});
        rd(CAL_OFS);
        chk("cal kept", cal, q);
        rd(SEC_OFS);
        chk("time reload", cal[7] ? 8'h00 : 8'h42, q);
    endtask

    task automatic end_sim;
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        core_clk   = 1'b0;
        rst_b      = 1'b0;
        vcc_ok     = 1'b1;
        osc_halted = 1'b1;
        mismatches = 0;
        n_tests    = 0;
        cycles     = 0;
        pulses     = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge core_clk);
        t_regs();
        t_wdog();
        t_power(8'h80, 1'b0, 8'h20);
        t_power(8'h25, 1'b0, 8'h30);
        t_power(8'h25, 1'b1, 8'h24);
        end_sim();
    end
endmodule
